// ---- osdcc_pkg.sv ----
// Shared constants and types of the on-screen display control command block.
// Assumes a single system clock of 100 MHz for every timing count.
package osdcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // First byte decoding
  localparam logic [3:0] OSDCC_OP_WRITE_ADDR = 4'h8;
  localparam logic [3:0] OSDCC_OP_CHAR_WRITE = 4'h9;
  localparam logic [3:0] OSDCC_OP_DC3        = 4'he;
  localparam logic [3:0] OSDCC_OP_EXPAND     = 4'hf;
  localparam logic [2:0] OSDCC_SUB_EXP0      = 3'h0;
  localparam logic [2:0] OSDCC_SUB_EXP1      = 3'h2;
  localparam logic [2:0] OSDCC_SUB_EXP2      = 3'h4;
  localparam logic [2:0] OSDCC_SUB_EXP3      = 3'h6;
  localparam int         OSDCC_BIT_FIRST     = 7;
  localparam int         OSDCC_BIT_BANK      = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Second byte field positions
  localparam int OSDCC_DC3_HALF_INT   = 6;
  localparam int OSDCC_DC3_SC_PIN_SEL = 5;
  localparam int OSDCC_DC3_OVL_SPAN   = 4;
  localparam int OSDCC_DC3_PIN_DIR    = 3;
  localparam int OSDCC_DC3_BG_HI      = 2;
  localparam int OSDCC_DC3_BG_LO      = 1;
  localparam int OSDCC_DC3_BURST_OFF  = 0;
  localparam int OSDCC_EX0_OSC_RANGE  = 6;
  localparam int OSDCC_EX1_FRAME_REV  = 6;
  localparam int OSDCC_EX1_PORT_B     = 5;
  localparam int OSDCC_EX1_PORT_A     = 4;
  localparam int OSDCC_EX1_VERTICAL_MASK_SIGNAL      = 3;
  localparam int OSDCC_EX1_VIN_SRC    = 2;
  localparam int OSDCC_EX1_VEDGE      = 1;
  localparam int OSDCC_EX1_VERTICAL_SEPARATION_TIME       = 0;
  localparam int OSDCC_EX3_FEEDBACK   = 3;
  localparam int OSDCC_ROWS_PER_BANK  = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Value codes and limits
  localparam logic [1:0] OSDCC_BG_SHOW    = 2'h0;
  localparam logic [1:0] OSDCC_BG_13IRE   = 2'h1;
  localparam logic [1:0] OSDCC_BG_23IRE   = 2'h2;
  localparam logic [3:0] OSDCC_ROW_MAX    = 4'hb;
  localparam logic [4:0] OSDCC_COL_MAX    = 5'h17;
  localparam logic [7:0] OSDCC_BYTE_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int OSDCC_CLK_PERIOD_NS  = 10;
  localparam int OSDCC_VERTICAL_SEPARATION_TIME_SHORT_NS  = 9300;
  localparam int OSDCC_VERTICAL_SEPARATION_TIME_LONG_NS   = 18600;
  localparam logic [11:0] OSDCC_VERTICAL_SEPARATION_TIME_SHORT_CYC = 12'(OSDCC_VERTICAL_SEPARATION_TIME_SHORT_NS / OSDCC_CLK_PERIOD_NS);
  localparam logic [11:0] OSDCC_VERTICAL_SEPARATION_TIME_LONG_CYC  = 12'(OSDCC_VERTICAL_SEPARATION_TIME_LONG_NS / OSDCC_CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    OSDCC_CMD_WRITE_ADDR,
    OSDCC_CMD_CHAR_WRITE,
    OSDCC_CMD_DC3,
    OSDCC_CMD_EXP0,
    OSDCC_CMD_EXP1,
    OSDCC_CMD_EXP2,
    OSDCC_CMD_EXP3,
    OSDCC_CMD_IGNORE
  } osdcc_cmd_t;

endpackage : osdcc_pkg

// ---- osdcc_link_rx.sv ----
// Serial byte receiver on the host's shift clock.
// Assumes data is MSB first, sampled on the rising shift clock edge,
// and that the shift clock only runs while chip select is low.
`timescale 1ns/10ps
`default_nettype none
module osdcc_link_rx
  import osdcc_pkg::*;
(
  // Link pins
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       sin,
  // System reset, raised only while the link idles
  input  wire logic       sys_rst,
  // Byte handed to the system domain
  output logic [7:0]      rx_byte_q,
  output logic            rx_toggle_q
);

  // Frame state clears with chip select; the handoff must survive it
  typedef struct packed {
    logic [6:0] shift;
    logic [2:0] count;
  } osdcc_rx_frame_t;

  typedef struct packed {
    logic [7:0] held;
    logic       toggle;
  } osdcc_rx_hand_t;

  osdcc_rx_frame_t frame_q;
  osdcc_rx_frame_t frame_d;
  osdcc_rx_hand_t  hand_q;
  osdcc_rx_hand_t  hand_d;

  always_comb
  begin
    frame_d       = frame_q;
    hand_d        = hand_q;
    frame_d.shift = {frame_q.shift[5:0], sin};
    frame_d.count = frame_q.count + 3'h1;
    if (frame_q.count == 3'h7)
    begin
      // Held byte stays stable for eight clocks, long enough for the crossing
      hand_d.held   = {frame_q.shift, sin};
      hand_d.toggle = ~hand_q.toggle;
    end
  end

  // Chip select high clears the bit counter; the clock is stopped then
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      frame_q <= '0;
    end
    else
    begin
      frame_q <= frame_d;
    end
  end

  // Toggle and byte survive the frame end; reset gives both sides one start value
  always_ff @(posedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hand_q <= '0;
    end
    else
    begin
      hand_q <= hand_d;
    end
  end

  assign rx_byte_q   = hand_q.held;
  assign rx_toggle_q = hand_q.toggle;

endmodule : osdcc_link_rx
`default_nettype wire

// ---- osdcc_ctrl.sv ----
// Control command interpreter of the on-screen display: decodes the two byte
// display control 3 and expansion commands plus the write address command.
// Assumes the host drives sclk/cs_n/sin and video timing inputs come from clk.
`timescale 1ns/10ps
`default_nettype none
module osdcc_ctrl
  import osdcc_pkg::*;
#(
  parameter int MODE_PINS = 4,
  parameter int SYNC_PINS = 3
)
(
  // System
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Serial link from the host
  input  wire logic                 sclk,
  input  wire logic                 cs_n,
  input  wire logic                 sin,
  // Mode pins, two-way
  input  wire logic [MODE_PINS-1:0] mode_pin_i,
  output logic      [MODE_PINS-1:0] mode_pin_o,
  output logic      [MODE_PINS-1:0] mode_pin_oe,
  // Video timing from the generator
  input  wire logic                 internal_sync,
  input  wire logic                 halftone_in,
  input  wire logic                 frame_area_in,
  input  wire logic                 char_area_in,
  input  wire logic                 vsync_sep_in,
  input  wire logic [SYNC_PINS-1:0] sync_normal_in,
  // Sync pins: sync detect, vertical, horizontal
  output logic      [SYNC_PINS-1:0] sync_pin_out,
  // Effective video standard
  output logic                      subcarrier_select,
  output logic                      color_system_select,
  output logic                      line_count_select,
  output logic                      secam_enable,
  // Display control
  output logic                      half_internal_sync,
  output logic                      overlay_switch_output,
  output logic                      background_show,
  output logic [1:0]                background_level,
  output logic                      burst_enable,
  output logic [11:0]               halftone_row_en,
  output logic                      osc_range_select,
  output logic                      osc_feedback_connect,
  output logic                      frame_on_reversed_chars,
  // Vertical sync options
  output logic                      vertical_mask_select,
  output logic                      vertical_in,
  output logic                      vertical_edge_polarity,
  output logic [11:0]               vertical_separation_cycles,
  // Display memory address
  output logic [3:0]                row_addr,
  output logic [4:0]                col_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain
  logic [7:0] rx_byte;
  logic       rx_toggle;

  osdcc_link_rx u_link_rx (
    .sclk        (sclk),
    .cs_n        (cs_n),
    .sin         (sin),
    .sys_rst     (sys_rst),
    .rx_byte_q   (rx_byte),
    .rx_toggle_q (rx_toggle)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic                 cs_s1;
    logic                 cs_s2;
    logic                 tog_s1;
    logic                 tog_s2;
    logic                 tog_s3;
    logic [MODE_PINS-1:0] mode_s1;
    logic [MODE_PINS-1:0] mode_s2;
    logic                 vin_s1;
    logic                 vin_s2;
    osdcc_cmd_t           cmd;
    logic                 bank;
    logic [3:0]           std_bits;
    logic                 half_int;
    logic                 sc_pin_sel;
    logic                 ovl_span;
    logic                 pin_dir;
    logic [1:0]           bg_code;
    logic                 burst_off;
    logic [11:0]          halftone;
    logic                 osc_range;
    logic                 frame_rev;
    logic                 port_set_b;
    logic                 port_set_a;
    logic                 vertical_mask_signal;
    logic                 vin_src;
    logic                 vedge;
    logic                 vertical_separation_time;
    logic [MODE_PINS-1:0] mode_sel;
    logic [MODE_PINS-1:0] mode_data;
    logic                 feedback;
    logic [SYNC_PINS-1:0] sync_sel;
    logic [SYNC_PINS-1:0] sync_data;
    logic [3:0]           row;
    logic [4:0]           col;
  } osdcc_state_t;

  osdcc_state_t st_q;
  osdcc_state_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding
  function automatic osdcc_cmd_t decode_first(input logic [7:0] b);
    osdcc_cmd_t c;
    c = OSDCC_CMD_IGNORE;
    unique case (b[7:4])
      OSDCC_OP_WRITE_ADDR: c = OSDCC_CMD_WRITE_ADDR;
      OSDCC_OP_CHAR_WRITE: c = OSDCC_CMD_CHAR_WRITE;
      OSDCC_OP_DC3:        c = OSDCC_CMD_DC3;
      OSDCC_OP_EXPAND:
      begin
        unique case (b[3:1])
          OSDCC_SUB_EXP0: c = OSDCC_CMD_EXP0;
          OSDCC_SUB_EXP1: c = OSDCC_CMD_EXP1;
          OSDCC_SUB_EXP2: c = OSDCC_CMD_EXP2;
          OSDCC_SUB_EXP3: c = OSDCC_CMD_EXP3;
          default:        c = OSDCC_CMD_IGNORE;
        endcase
      end
      default:             c = OSDCC_CMD_IGNORE;
    endcase
    return c;
  endfunction : decode_first

  function automatic logic is_expansion(input osdcc_cmd_t c);
    return (c == OSDCC_CMD_EXP0) || (c == OSDCC_CMD_EXP1) ||
           (c == OSDCC_CMD_EXP2) || (c == OSDCC_CMD_EXP3);
  endfunction : is_expansion

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic       byte_event;
  logic       first_byte;
  osdcc_cmd_t new_cmd;

  assign byte_event = st_q.tog_s2 ^ st_q.tog_s3;
  assign first_byte = rx_byte[OSDCC_BIT_FIRST];
  assign new_cmd    = decode_first(rx_byte);

  always_comb
  begin
    st_d = st_q;
    st_d.cs_s1   = cs_n;
    st_d.cs_s2   = st_q.cs_s1;
    st_d.tog_s1  = rx_toggle;
    st_d.tog_s2  = st_q.tog_s1;
    st_d.tog_s3  = st_q.tog_s2;
    st_d.mode_s1 = mode_pin_i;
    st_d.mode_s2 = st_q.mode_s1;
    st_d.vin_s1  = vsync_sep_in;
    st_d.vin_s2  = st_q.vin_s1;
    // A byte that completes as chip select rises still counts for its own frame
    if (byte_event)
    begin
      if (st_q.cmd == OSDCC_CMD_CHAR_WRITE)
      begin
        // Locked in character data until chip select rises; data handled elsewhere
        st_d.cmd = OSDCC_CMD_CHAR_WRITE;
      end
      else if (first_byte)
      begin
        st_d.cmd = new_cmd;
        if (is_expansion(new_cmd))
        begin
          st_d.bank = rx_byte[OSDCC_BIT_BANK];
        end
        if (new_cmd == OSDCC_CMD_DC3)
        begin
          st_d.std_bits = rx_byte[3:0];
        end
        if ((new_cmd == OSDCC_CMD_WRITE_ADDR) && (rx_byte[3:0] <= OSDCC_ROW_MAX))
        begin
          st_d.row = rx_byte[3:0];
        end
      end
      else
      begin
        // Second bytes: only documented field bits are taken
        unique case (st_q.cmd)
          OSDCC_CMD_WRITE_ADDR:
          begin
            if (rx_byte[4:0] <= OSDCC_COL_MAX)
            begin
              st_d.col = rx_byte[4:0];
            end
          end
          OSDCC_CMD_DC3:
          begin
            st_d.half_int   = rx_byte[OSDCC_DC3_HALF_INT];
            st_d.sc_pin_sel = rx_byte[OSDCC_DC3_SC_PIN_SEL];
            st_d.ovl_span   = rx_byte[OSDCC_DC3_OVL_SPAN];
            st_d.pin_dir    = rx_byte[OSDCC_DC3_PIN_DIR];
            st_d.bg_code    = {rx_byte[OSDCC_DC3_BG_HI], rx_byte[OSDCC_DC3_BG_LO]};
            st_d.burst_off  = rx_byte[OSDCC_DC3_BURST_OFF];
          end
          OSDCC_CMD_EXP0:
          begin
            st_d.osc_range = rx_byte[OSDCC_EX0_OSC_RANGE];
            if (st_q.bank)
            begin
              st_d.halftone[11:6] = rx_byte[5:0];
            end
            else
            begin
              st_d.halftone[5:0] = rx_byte[5:0];
            end
          end
          OSDCC_CMD_EXP1:
          begin
            st_d.frame_rev  = rx_byte[OSDCC_EX1_FRAME_REV];
            st_d.port_set_b = rx_byte[OSDCC_EX1_PORT_B];
            st_d.port_set_a = rx_byte[OSDCC_EX1_PORT_A];
            st_d.vertical_mask_signal      = rx_byte[OSDCC_EX1_VERTICAL_MASK_SIGNAL];
            st_d.vin_src    = rx_byte[OSDCC_EX1_VIN_SRC];
            st_d.vedge      = rx_byte[OSDCC_EX1_VEDGE];
            st_d.vertical_separation_time       = rx_byte[OSDCC_EX1_VERTICAL_SEPARATION_TIME];
          end
          OSDCC_CMD_EXP2:
          begin
            if (st_q.port_set_a)
            begin
              st_d.mode_sel = rx_byte[MODE_PINS-1:0];
            end
            else
            begin
              st_d.mode_data = rx_byte[MODE_PINS-1:0];
            end
          end
          OSDCC_CMD_EXP3:
          begin
            st_d.feedback = rx_byte[OSDCC_EX3_FEEDBACK];
            if (st_q.port_set_b)
            begin
              st_d.sync_sel = rx_byte[SYNC_PINS-1:0];
            end
            else
            begin
              st_d.sync_data = rx_byte[SYNC_PINS-1:0];
            end
          end
          OSDCC_CMD_CHAR_WRITE,
          OSDCC_CMD_IGNORE:
          begin
            st_d.cmd = st_q.cmd;
          end
        endcase
      end
    end
    if (st_q.cs_s2)
    begin
      st_d.cmd = OSDCC_CMD_WRITE_ADDR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q     <= '0;
      st_q.cs_s1  <= 1'b1;
      st_q.cs_s2  <= 1'b1;
      st_q.cmd    <= OSDCC_CMD_WRITE_ADDR;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic [3:0]           std_eff;
  logic [MODE_PINS-1:0] mode_normal;

  // Board must hold the mode pins low when the command is to decide
  assign std_eff = st_q.std_bits | st_q.mode_s2;

  assign subcarrier_select   = std_eff[3];
  assign color_system_select = std_eff[2];
  assign line_count_select   = std_eff[1];
  assign secam_enable        = std_eff[0];

  always_comb
  begin
    mode_normal    = st_q.std_bits;
    // Subcarrier pin carries halftone or a high level while internally synced
    mode_normal[3] = st_q.sc_pin_sel ? internal_sync : halftone_in;
  end

  generate
    for (genvar i = 0; i < MODE_PINS; i++)
    begin : g_mode_pin
      assign mode_pin_o[i] = (st_q.port_set_a && !st_q.mode_sel[i]) ?
                             mode_normal[i] : st_q.mode_data[i];
      assign mode_pin_oe[i] = st_q.pin_dir;
    end
    for (genvar j = 0; j < SYNC_PINS; j++)
    begin : g_sync_pin
      assign sync_pin_out[j] = (st_q.port_set_b && !st_q.sync_sel[j]) ?
                               sync_normal_in[j] : st_q.sync_data[j];
    end
  endgenerate

  assign half_internal_sync    = st_q.half_int;
  assign overlay_switch_output = (secam_enable && !st_q.ovl_span) ?
                                 frame_area_in : char_area_in;
  assign background_show  = !internal_sync || (st_q.bg_code == OSDCC_BG_SHOW);
  assign background_level = internal_sync ? st_q.bg_code : OSDCC_BG_SHOW;
  assign burst_enable     = !(st_q.burst_off && internal_sync && |st_q.bg_code);
  assign halftone_row_en  = st_q.halftone;
  assign osc_range_select = st_q.osc_range;
  assign osc_feedback_connect    = st_q.feedback;
  assign frame_on_reversed_chars = st_q.frame_rev;

  assign vertical_mask_select   = st_q.vertical_mask_signal;
  // Mode pin zero as vertical input only makes sense with the pins as inputs
  assign vertical_in            = st_q.vin_src ? st_q.mode_s2[0] : st_q.vin_s2;
  assign vertical_edge_polarity = st_q.vedge;
  assign vertical_separation_cycles = st_q.vertical_separation_time ? OSDCC_VERTICAL_SEPARATION_TIME_LONG_CYC :
                                                  OSDCC_VERTICAL_SEPARATION_TIME_SHORT_CYC;

  assign row_addr = st_q.row;
  assign col_addr = st_q.col;

endmodule : osdcc_ctrl
`default_nettype wire

// ---- osdcc_ctrl_sva.sv ----
// Port assertions for the control command block.
// Assumes sys_rst is synchronous to clk; bound into every osdcc_ctrl.
`timescale 1ns/10ps
`default_nettype none
module osdcc_ctrl_sva
  import osdcc_pkg::*;
#(
  parameter int MODE_PINS = 4,
  parameter int SYNC_PINS = 3
)
(
  // System and link
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic                 cs_n,
  // Pins and video inputs
  input wire logic [MODE_PINS-1:0] mode_pin_i,
  input wire logic [MODE_PINS-1:0] mode_pin_oe,
  input wire logic                 internal_sync,
  input wire logic                 frame_area_in,
  input wire logic                 char_area_in,
  // Observed outputs
  input wire logic                 subcarrier_select,
  input wire logic                 secam_enable,
  input wire logic                 half_internal_sync,
  input wire logic                 overlay_switch_output,
  input wire logic                 background_show,
  input wire logic                 burst_enable,
  input wire logic [11:0]          halftone_row_en,
  input wire logic                 osc_range_select,
  input wire logic                 frame_on_reversed_chars,
  input wire logic [11:0]          vertical_separation_cycles,
  input wire logic [3:0]           row_addr,
  input wire logic [4:0]           col_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Eight idle samples cover the crossing latency of the last byte
  sequence link_idle_s;
    cs_n [*8];
  endsequence
  sequence pin3_high_s;
    mode_pin_i[3] [*3];
  endsequence

  reset_clear_a:
    assert property ($fell(sys_rst) |-> halftone_row_en == 12'h000 && mode_pin_oe == '0
      && burst_enable && vertical_separation_cycles == OSDCC_VERTICAL_SEPARATION_TIME_SHORT_CYC)
    else $error("control registers not cleared by reset");
  pin_or_a:
    assert property (pin3_high_s |-> subcarrier_select)
    else $error("mode pin not ORed into standard");
  dir_all_a:
    assert property (mode_pin_oe == '0 || mode_pin_oe == '1)
    else $error("mode pin enables split");
  bg_ext_a:
    assert property (!internal_sync |-> background_show)
    else $error("background code acted while externally synced");
  burst_bg_a:
    assert property (internal_sync && background_show |-> burst_enable)
    else $error("burst stopped with background code zero");
  overlay_span_a:
    assert property (secam_enable ? (overlay_switch_output == frame_area_in
      || overlay_switch_output == char_area_in) : overlay_switch_output == char_area_in)
    else $error("overlay switch follows wrong area");
  vertical_separation_time_pair_a:
    assert property (vertical_separation_cycles == OSDCC_VERTICAL_SEPARATION_TIME_SHORT_CYC
      || vertical_separation_cycles == OSDCC_VERTICAL_SEPARATION_TIME_LONG_CYC)
    else $error("separation interval off the two values");
  addr_range_a:
    assert property (row_addr <= OSDCC_ROW_MAX && col_addr <= OSDCC_COL_MAX)
    else $error("display address out of range");
  idle_hold_a:
    assert property (link_idle_s |-> $stable({halftone_row_en, osc_range_select, row_addr,
      col_addr, half_internal_sync, frame_on_reversed_chars, mode_pin_oe}))
    else $error("control register changed with link idle");
endmodule : osdcc_ctrl_sva

bind osdcc_ctrl osdcc_ctrl_sva #(.MODE_PINS(MODE_PINS), .SYNC_PINS(SYNC_PINS)) sva_i (
  .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .mode_pin_i(mode_pin_i),
  .mode_pin_oe(mode_pin_oe), .internal_sync(internal_sync), .frame_area_in(frame_area_in),
  .char_area_in(char_area_in), .subcarrier_select(subcarrier_select),
  .secam_enable(secam_enable), .half_internal_sync(half_internal_sync),
  .overlay_switch_output(overlay_switch_output), .background_show(background_show),
  .burst_enable(burst_enable), .halftone_row_en(halftone_row_en),
  .osc_range_select(osc_range_select), .frame_on_reversed_chars(frame_on_reversed_chars),
  .vertical_separation_cycles(vertical_separation_cycles), .row_addr(row_addr),
  .col_addr(col_addr));
`default_nettype wire

// ---- osdcc_host_model.sv ----
// Host controller model: shifts command bytes MSB first on a 6 ns clock.
// Assumes the bench calls its tasks; the shift clock idles low between frames.
`timescale 1ns/10ps
`default_nettype none
module osdcc_host_model
(
  // Link pins toward the device
  output logic sclk,
  output logic cs_n,
  output logic sin
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sin  = 1'b1;
  end

  task automatic open_frame();
    // Odd offset keeps the link unrelated in phase to clk
    #2.3;
    cs_n = 1'b0;
    #3;
  endtask : open_frame

  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sin = b[i];
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
  endtask : send_byte

  task automatic close_frame();
    #3 cs_n = 1'b1;
    // Released data line must not keep showing the last bit
    sin = ~sin;
    #80;
  endtask : close_frame
endmodule : osdcc_host_model
`default_nettype wire

// ---- tb_osdcc_ctrl.sv ----
// Self-checking bench for the control command block.
// Assumes the host model drives the link; the bench drives video inputs.
`timescale 1ns/10ps
`default_nettype none
module tb_osdcc_ctrl;
  import osdcc_pkg::*;
  logic        clk, sys_rst, sclk, cs_n, sin, internal_sync, halftone_in;
  logic        frame_area_in, char_area_in, vsync_sep_in, subcarrier_select;
  logic        color_system_select, line_count_select, secam_enable, half_internal_sync;
  logic        overlay_switch_output, background_show, burst_enable, osc_range_select;
  logic        osc_feedback_connect, frame_on_reversed_chars, vertical_mask_select;
  logic        vertical_in, vertical_edge_polarity;
  logic [1:0]  background_level;
  logic [2:0]  sync_normal_in, sync_pin_out;
  logic [3:0]  mode_drv, mode_pin_i, mode_pin_o, mode_pin_oe, row_addr, std_bits;
  logic [4:0]  col_addr;
  logic [11:0] halftone_row_en, vertical_separation_cycles;
  int          mismatches, total_checks;

  // Wire level of the two-way mode pins
  assign mode_pin_i = (mode_pin_oe & mode_pin_o) | (~mode_pin_oe & mode_drv);
  assign std_bits = {subcarrier_select, color_system_select, line_count_select, secam_enable};

  osdcc_ctrl uut (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .sin(sin),
    .mode_pin_i(mode_pin_i), .mode_pin_o(mode_pin_o), .mode_pin_oe(mode_pin_oe),
    .internal_sync(internal_sync), .halftone_in(halftone_in), .frame_area_in(frame_area_in),
    .char_area_in(char_area_in), .vsync_sep_in(vsync_sep_in), .sync_normal_in(sync_normal_in),
    .sync_pin_out(sync_pin_out), .subcarrier_select(subcarrier_select),
    .color_system_select(color_system_select), .line_count_select(line_count_select),
    .secam_enable(secam_enable), .half_internal_sync(half_internal_sync),
    .overlay_switch_output(overlay_switch_output), .background_show(background_show),
    .background_level(background_level), .burst_enable(burst_enable),
    .halftone_row_en(halftone_row_en), .osc_range_select(osc_range_select),
    .osc_feedback_connect(osc_feedback_connect),
    .frame_on_reversed_chars(frame_on_reversed_chars),
    .vertical_mask_select(vertical_mask_select), .vertical_in(vertical_in),
    .vertical_edge_polarity(vertical_edge_polarity),
    .vertical_separation_cycles(vertical_separation_cycles), .row_addr(row_addr),
    .col_addr(col_addr));
  osdcc_host_model host (.sclk(sclk), .cs_n(cs_n), .sin(sin));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic frame(input logic [7:0] a, input logic [7:0] b);
    host.open_frame();
    host.send_byte(a);
    host.send_byte(b);
    host.close_frame();
    tick(2);
  endtask : frame

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals();
    chk(halftone_row_en, 12'h000);
    chk(12'({mode_pin_oe, std_bits, burst_enable}), 12'h001);
    chk(vertical_separation_cycles, OSDCC_VERTICAL_SEPARATION_TIME_SHORT_CYC);
  endtask : t_reset_vals

  task automatic t_dc3();
    mode_drv <= 4'h0;
    internal_sync <= 1'b1;
    frame_area_in <= 1'b1;
    host.open_frame();
    host.send_byte(8'he5);
    host.send_byte(8'h41);
    tick(8);
    chk(12'(std_bits), 12'h005);
    chk(12'({half_internal_sync, burst_enable}), 12'h003);
    host.send_byte(8'h0d);
    host.close_frame();
    tick(2);
    chk(12'({half_internal_sync, mode_pin_oe}), 12'h00f);
    chk(12'({background_show, burst_enable, background_level}), 12'h002);
    chk(12'(overlay_switch_output), 12'h001);
    {frame_area_in, char_area_in} <= 2'b01;
    frame(8'he1, 8'h15);
    chk(12'(overlay_switch_output), 12'h001);
    internal_sync <= 1'b0;
    tick(2);
    chk(12'({background_show, background_level}), 12'h004);
    frame(8'he0, 8'h00);
    mode_drv <= 4'h8;
    tick(4);
    chk(12'(std_bits), 12'h008);
    mode_drv <= 4'h0;
  endtask : t_dc3

  task automatic t_halftone();
    host.open_frame();
    host.send_byte(8'hf0);
    host.send_byte(8'h45);
    host.send_byte(8'hf1);
    host.send_byte(8'h6a);
    host.close_frame();
    tick(2);
    chk(halftone_row_en, 12'ha85);
    chk(12'(osc_range_select), 12'h001);
  endtask : t_halftone

  task automatic t_vert();
    vsync_sep_in <= 1'b1;
    frame(8'hf4, 8'h49);
    chk(12'({frame_on_reversed_chars, vertical_mask_select, vertical_in}), 12'h007);
    chk(vertical_separation_cycles, OSDCC_VERTICAL_SEPARATION_TIME_LONG_CYC);
    frame(8'hf5, 8'h06);
    chk(12'({frame_on_reversed_chars, vertical_mask_select, vertical_edge_polarity,
        vertical_in}), 12'h002);
    chk(vertical_separation_cycles, OSDCC_VERTICAL_SEPARATION_TIME_SHORT_CYC);
  endtask : t_vert

  task automatic t_addr();
    host.open_frame();
    host.send_byte(8'h03);
    host.close_frame();
    tick(2);
    chk(12'({row_addr, col_addr}), 12'h003);
    frame(8'h8b, 8'h17);
    chk(12'({row_addr, col_addr}), 12'h177);
    frame(8'h8c, 8'h18);
    chk(12'({row_addr, col_addr}), 12'h177);
  endtask : t_addr

  task automatic t_ports();
    sys_rst <= 1'b1;
    tick(3);
    sys_rst <= 1'b0;
    tick(4);
    chk(halftone_row_en, 12'h000);
    sync_normal_in <= 3'h7;
    halftone_in <= 1'b1;
    host.open_frame();
    host.send_byte(8'hf8);
    host.send_byte(8'h0a);
    host.send_byte(8'hfc);
    host.send_byte(8'h00);
    host.send_byte(8'hf4);
    host.send_byte(8'h30);
    host.send_byte(8'hf8);
    host.send_byte(8'h79);
    host.send_byte(8'hfc);
    host.send_byte(8'h7a);
    host.close_frame();
    tick(2);
    chk(12'(mode_pin_o), 12'h008);
    chk(12'(sync_pin_out), 12'h005);
    chk(12'(osc_feedback_connect), 12'h001);
    frame(8'hf8, 8'h00);
    chk(12'(mode_pin_o), 12'h008);
    frame(8'he0, 8'h20);
    chk(12'(mode_pin_o), 12'h000);
  endtask : t_ports

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst = 1'b1;
    mode_drv = 4'h0;
    internal_sync = 1'b0;
    halftone_in = 1'b0;
    frame_area_in = 1'b0;
    char_area_in = 1'b0;
    vsync_sep_in = 1'b0;
    sync_normal_in = 3'h0;
    mismatches = 0;
    total_checks = 0;
    tick(3);
    sys_rst <= 1'b0;
    tick(4);
    t_reset_vals();
    t_dc3();
    t_halftone();
    t_vert();
    t_addr();
    t_ports();
    print_verdict();
  end

  // Whole sequence needs a few hundred cycles
  initial
  begin
    tick(20000);
    mismatches++;
    print_verdict();
  end
endmodule : tb_osdcc_ctrl
`default_nettype wire
